// File: common/sflash_pkg.sv
// Constants, types and opcode values for the serial flash command front end.
// Assumes a single 25 MHz system clock; all link pins are asynchronous to it.
// Operation
// - All bytes travel most significant bit first.
// - Releasing select ends the current command.
// - Unknown opcode: ignore input until next select.
// - Early release before address complete: no operation.
// - Three address bytes; top three bits ignored.
// - Decode block erase 4K, 32K, 64K opcodes.
// - Decode program opcode: address then data in.
// - Decode protection readback: address then data out.
// - Identification readout returns one to four bytes.
// - Decode power-down and resume opcodes, no arguments.
// - Read address counter advances automatically.
// - Fast read skips one dummy byte.
// - Slow read has no dummy byte.
// - After header, each clock shifts data out.
// - Read address wraps to zero without delay.
// - Release stops read and floats the output.
// - Release may come mid-byte; device accepts it.
// - Sample input on rise, change output on fall.
// - Two chip erase opcodes decode identically.
package sflash_pkg;

	localparam int          BYTE_W     = 8;         // Link byte width
	localparam int          ADDR_W     = 21;        // Decoded array address width
	localparam int          ADDR_BYTES = 3;         // Address bytes per command
	localparam int          FIFO_DEPTH = 16;        // Read prefetch depth
	localparam logic [2:0]  BIT_LAST   = 3'h7;      // Index of last bit in a byte
	localparam logic [1:0]  ADDR_LAST  = 2'h2;      // Index of last address byte
	localparam logic [2:0]  ID_MAX     = 3'h4;      // Identification bytes driven
	localparam logic [7:0]  EMPTY_FILL = 8'hFF;     // Byte sent if prefetch runs dry

	// Opcodes
	localparam logic [7:0] OP_READ_FAST  = 8'h0B;
	localparam logic [7:0] OP_READ_SLOW  = 8'h03;
	localparam logic [7:0] OP_ERASE_4K   = 8'h20;
	localparam logic [7:0] OP_ERASE_32K  = 8'h52;
	localparam logic [7:0] OP_ERASE_64K  = 8'hD8;
	localparam logic [7:0] OP_CHIP_ERA_A = 8'h60;
	localparam logic [7:0] OP_CHIP_ERA_B = 8'hC7;
	localparam logic [7:0] OP_PROGRAM    = 8'h02;
	localparam logic [7:0] OP_WR_ENABLE  = 8'h06;
	localparam logic [7:0] OP_WR_DISABLE = 8'h04;
	localparam logic [7:0] OP_PROTECT    = 8'h36;
	localparam logic [7:0] OP_UNPROTECT  = 8'h39;
	localparam logic [7:0] OP_RD_PROT    = 8'h3C;
	localparam logic [7:0] OP_RD_STATUS  = 8'h05;
	localparam logic [7:0] OP_WR_STATUS  = 8'h01;
	localparam logic [7:0] OP_RD_ID      = 8'h9F;
	localparam logic [7:0] OP_PWR_DOWN   = 8'hB9;
	localparam logic [7:0] OP_RESUME     = 8'hAB;

	// Direction of the data phase
	typedef enum logic [1:0] {DIR_NONE, DIR_OUT, DIR_IN} dir_e;

	// Command framing states
	typedef enum logic [2:0] {
		ST_IDLE, ST_OPCODE, ST_ADDR, ST_DUMMY, ST_OUT, ST_IN, ST_SKIP, ST_IGNORE
	} state_e;

	// Shape of one command
	typedef struct packed {
		logic known;   // Opcode supported
		logic addr;    // Three address bytes follow
		logic dummy;   // One dummy byte follows the address
		dir_e dir;     // Data phase direction
	} op_info_s;

endpackage

// File: sim/sflash_cmd_read_properties.sv
// Port-level checks for the flash command and read front end.
// Assumes sck halves last at least 4 clocks and pins arrive unsynchronised.
`timescale 1ns/100ps
module sflash_cmd_read_checker (
	// System
	input wire logic                          clock,
	input wire logic                          rst_b,
	// Link
	input wire logic                          csB,
	input wire logic                          sck,
	input wire logic                          si,
	input wire logic                          so_q,
	input wire logic                          soOe_q,
	// Array
	input wire logic                          arrayRd_q,
	input wire logic [sflash_pkg::ADDR_W-1:0] arrayAddr_q,
	input wire logic [sflash_pkg::BYTE_W-1:0] arrayData,
	// Command, data in, replies
	input wire logic [sflash_pkg::BYTE_W-1:0] cmdOp_q,
	input wire logic [sflash_pkg::ADDR_W-1:0] cmdAddr_q,
	input wire logic                          cmdExec_q,
	input wire logic [sflash_pkg::BYTE_W-1:0] rxData_q,
	input wire logic                          rxValid_q,
	input wire logic [sflash_pkg::BYTE_W-1:0] respData,
	input wire logic                          respTake_q
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	logic [sflash_pkg::ADDR_W-1:0] lastAddr_q; // Address of the previous fetch
	logic                          hasLast_q;  // A fetch was seen in this frame

	// Forget the previous fetch once select is high, so frames never chain
	always_ff @(posedge clock) begin
		if (!rst_b || csB) begin
			hasLast_q <= 1'b0;
		end else if (arrayRd_q) begin
			hasLast_q <= 1'b1;
		end
	end
	// Remember each fetch address
	always_ff @(posedge clock) begin
		if (arrayRd_q) begin
			lastAddr_q <= arrayAddr_q;
		end
	end

	a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> !soOe_q && !cmdExec_q && !arrayRd_q)
		else $error("Outputs active after reset");
	a_addr_step: assert property (arrayRd_q && hasLast_q |-> arrayAddr_q == lastAddr_q + 1'b1)
		else $error("Fetch address did not advance by one");
	a_oe_floats: assert property (csB [*5] |-> !soOe_q)
		else $error("Output driven while deselected");
	a_out_on_fall: assert property (soOe_q && $changed(so_q) || $rose(soOe_q) |-> !$past(sck, 2))
		else $error("Output changed away from a falling sck");
	a_exec_release: assert property (cmdExec_q |-> $past(csB, 2) ##1 !cmdExec_q)
		else $error("Command pulse not tied to release");
	a_rd_in_frame: assert property (arrayRd_q |-> !$past(csB, 6) ##1 !arrayRd_q)
		else $error("Fetch outside a frame");
	a_rx_in_frame: assert property (rxValid_q |-> !$past(csB, 3) ##1 !rxValid_q)
		else $error("Data byte outside a frame");
	a_take_pulse: assert property (respTake_q |=> !respTake_q)
		else $error("Reply take longer than one cycle");
endmodule

bind sflash_cmd_read sflash_cmd_read_checker i_chk (.clock(clock), .rst_b(rst_b), .csB(csB),
	.sck(sck), .si(si), .so_q(so_q), .soOe_q(soOe_q), .arrayRd_q(arrayRd_q),
	.arrayAddr_q(arrayAddr_q), .arrayData(arrayData), .cmdOp_q(cmdOp_q), .cmdAddr_q(cmdAddr_q),
	.cmdExec_q(cmdExec_q), .rxData_q(rxData_q), .rxValid_q(rxValid_q), .respData(respData),
	.respTake_q(respTake_q));

// File: sim/spi_master_model.sv
// Link master model: frames, shifts MSB first, samples the output line.
// Assumes the bench clock paces it; one link period is 8 clocks (320 ns).
`timescale 1ns/100ps
module spi_master_model (
	// Pacing
	input  wire logic clock,
	// Link
	output logic      csB,
	output logic      sck,
	output logic      si,
	input  wire logic soLine
);
	logic idleHigh; // Rest level of sck, high in mode 3

	initial begin
		csB = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		idleHigh = 1'b0;
	end

	// Settle sck at its rest level, then select
	task automatic open_frame(input logic m3);
		idleHigh <= m3;
		sck <= m3;
		repeat (4) @(posedge clock);
		csB <= 1'b0;
		repeat (4) @(posedge clock);
	endtask

	// Data set after a fall, line read just before the rise
	task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			sck <= 1'b0;
			si <= tx[i];
			repeat (3) @(posedge clock);
			@(negedge clock);
			rx[i] = soLine;
			@(posedge clock);
			sck <= 1'b1;
			repeat (4) @(posedge clock);
		end
	endtask

	// Release select at any bit; the data line must not keep its last bit
	task automatic close_frame();
		sck <= idleHigh;
		repeat (4) @(posedge clock);
		csB <= 1'b1;
		si <= ~si;
		repeat (8) @(posedge clock);
	endtask
endmodule

// File: sim/tb.sv
// Self-checking bench for the flash command and read front end.
// Assumes the master model drives the link; array and reply source live here.
`timescale 1ns/100ps
module tb;
	logic clock, rst_b, csB, sck, si, so_q, soOe_q, arrayRd_q, cmdExec_q, rxValid_q, respTake_q;
	logic [sflash_pkg::ADDR_W-1:0] arrayAddr_q, cmdAddr_q;
	logic [sflash_pkg::BYTE_W-1:0] arrayData, respData, cmdOp_q, rxData_q, lastRx, rx;
	wire                           soLine; // Floats when the device lets go
	int                            nFail, comparisons, nExec, nRd, nRx, cycles;

	assign soLine = soOe_q ? so_q : 1'bz;

	sflash_cmd_read i_dut (.clock(clock), .rst_b(rst_b), .csB(csB), .sck(sck), .si(si),
		.so_q(so_q), .soOe_q(soOe_q), .arrayRd_q(arrayRd_q), .arrayAddr_q(arrayAddr_q),
		.arrayData(arrayData), .cmdOp_q(cmdOp_q), .cmdAddr_q(cmdAddr_q), .cmdExec_q(cmdExec_q),
		.rxData_q(rxData_q), .rxValid_q(rxValid_q), .respData(respData), .respTake_q(respTake_q));
	spi_master_model i_master (.clock(clock), .csB(csB), .sck(sck), .si(si), .soLine(soLine));

	// Array content is a function of address, so a wrong address shows
	function automatic logic [7:0] arr(input logic [20:0] a);
		return a[7:0] ^ a[15:8] ^ {3'h0, a[20:16]};
	endfunction

	// The array answers in the cycle of the strobe, when the prefetch stores it
	assign arrayData = arr(arrayAddr_q);

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// Reply source, pulse counters and hang guard
	always @(posedge clock) begin
		if (respTake_q) respData <= respData + 8'h11;
		if (rxValid_q) lastRx <= rxData_q;
		if (cmdExec_q) nExec++;
		if (arrayRd_q) nRd++;
		if (rxValid_q) nRx++;
		cycles++;
		if (cycles == 60000) begin
			nFail++;
			print_verdict();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			nFail++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Opcode then n address bytes, high byte first
	task automatic hdr(input logic m3, input logic [7:0] op, input logic [23:0] ad, input int n);
		i_master.open_frame(m3);
		i_master.shift(op, 8, rx);
		for (int k = 0; k < n; k++) begin
			i_master.shift(ad[23 - 8 * k -: 8], 8, rx);
		end
	endtask

	// Slow read with top address bits set, released mid-byte
	task automatic t_read_slow();
		hdr(1'b0, 8'h03, 24'hE00010, 3);
		for (int k = 0; k < 3; k++) begin
			i_master.shift(8'h00, 8, rx);
			check(rx, arr(21'h000010 + k));
		end
		i_master.shift(8'h00, 3, rx);
		i_master.close_frame();
		check(soOe_q, 1'b0);
		check(cmdAddr_q, 21'h000010);
	endtask

	// Fast read in mode 3 across the top of the array
	task automatic t_read_wrap();
		hdr(1'b1, 8'h0B, 24'h1FFFFF, 3);
		i_master.shift(8'h5A, 8, rx);
		check(rx, 8'hZZ);
		i_master.shift(8'h00, 8, rx);
		check(rx, arr(21'h1FFFFF));
		i_master.shift(8'h00, 8, rx);
		check(rx, arr(21'h000000));
		i_master.close_frame();
	endtask

	// Unsupported opcode followed by what looks like a read
	task automatic t_unknown();
		nRd = 0;
		nExec = 0;
		hdr(1'b0, 8'hFF, 24'h030000, 3);
		i_master.shift(8'h00, 8, rx);
		check(rx, 8'hZZ);
		i_master.close_frame();
		check(nRd, 0);
		check(nExec, 0);
	endtask

	// Early releases, then every argument-only opcode with a trailing byte
	task automatic t_commands();
		logic [7:0] ops [11] = '{8'h20, 8'h52, 8'hD8, 8'h36, 8'h39, 8'h60, 8'hC7, 8'hB9,
		                         8'hAB, 8'h06, 8'h04};
		nExec = 0;
		hdr(1'b0, 8'h20, 24'h123456, 2);
		i_master.close_frame();
		i_master.open_frame(1'b0);
		i_master.shift(8'h20, 5, rx);
		i_master.close_frame();
		check(nExec, 0);
		for (int k = 0; k < 11; k++) begin
			hdr(1'b0, ops[k], 24'hEABCDE, (k < 5) ? 3 : 0);
			i_master.shift(8'h77, 8, rx);
			i_master.close_frame();
			check(cmdOp_q, ops[k]);
			check(nExec, k + 1);
			if (k < 5) check(cmdAddr_q, 21'h0ABCDE);
		end
	endtask

	// Program data in, with a partial byte dropped at release
	task automatic t_program();
		nRx = 0;
		hdr(1'b0, 8'h02, 24'h000102, 3);
		i_master.shift(8'hA5, 8, rx);
		i_master.shift(8'h3C, 8, rx);
		i_master.shift(8'hFF, 3, rx);
		i_master.close_frame();
		check(nRx, 2);
		check(lastRx, 8'h3C);
	endtask

	// Protection readback, then identification limited to four bytes
	task automatic t_replies();
		respData <= 8'h40;
		hdr(1'b0, 8'h3C, 24'h000000, 3);
		for (int k = 0; k < 2; k++) begin
			i_master.shift(8'h00, 8, rx);
			check(rx, 8'h40 + 8'h11 * k);
		end
		i_master.close_frame();
		respData <= 8'h40;
		hdr(1'b0, 8'h9F, 24'h000000, 0);
		for (int k = 0; k < 5; k++) begin
			i_master.shift(8'h00, 8, rx);
			check(rx, (k < 4) ? 8'h40 + 8'h11 * k : 8'hZZ);
		end
		i_master.close_frame();
	endtask

	task automatic print_verdict();
		$display("Mismatches %0d, comparisons %0d", nFail, comparisons);
		if (nFail == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		rst_b = 1'b0;
		respData = 8'h00;
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		check(cmdOp_q, 8'h00);
		check(soOe_q, 1'b0);
		t_read_slow();
		t_read_wrap();
		t_unknown();
		t_commands();
		t_program();
		t_replies();
		print_verdict();
	end
endmodule

// File: src/data_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a flush.
// Assumes one clock; flush wins over a write in the same cycle.
`timescale 1ns/100ps
module data_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// System
	input  wire logic             clock,
	input  wire logic             rst_b,
	input  wire logic             flush,
	// Fill side
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	// Drain side
	output logic                  outValid,
	output logic [WIDTH-1:0]      outData,
	input  wire logic             outReady
);

	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];   // Storage
	logic [PTR_W-1:0] wrPtr_q;       // Next write slot
	logic [PTR_W-1:0] rdPtr_q;       // Next read slot
	logic [PTR_W:0]   count_q;       // Words held
	logic             push;
	logic             pop;

	assign inReady  = (count_q != (PTR_W+1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign outData  = mem[rdPtr_q];
	assign push     = inValid & inReady & ~flush;
	assign pop      = outValid & outReady & ~flush;

	// Storage write, no reset needed
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wrPtr_q] <= inData;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clock) begin
		if (!rst_b || flush) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wrPtr_q <= (wrPtr_q == PTR_W'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= (rdPtr_q == PTR_W'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
			end
			count_q <= count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
		end
	end

endmodule

// File: src/pin_sync.sv
// Two-flop synchroniser for one asynchronous pin.
// Assumes the pin may change at any time relative to clock.
`timescale 1ns/100ps
module pin_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	// System
	input  wire logic clock,
	input  wire logic rst_b,
	// Pin and result
	input  wire logic pinIn,
	output logic      pinOut
);

	logic meta_q;   // First stage, read only by the second

	// Both stages reset to the pin's idle level
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			meta_q <= RESET_VAL;
			pinOut <= RESET_VAL;
		end else begin
			meta_q <= pinIn;
			pinOut <= meta_q;
		end
	end

endmodule

// File: src/sflash_cmd_read.sv
// Serial flash command framing, opcode decode and array read path.
// Assumes csB, sck and si are asynchronous pins sampled by clock, and
// that the array shows data for arrayAddr_q while arrayRd_q is high.
`timescale 1ns/100ps
module sflash_cmd_read #(
	parameter int FIFO_W = sflash_pkg::BYTE_W,
	parameter int FIFO_D = sflash_pkg::FIFO_DEPTH
) (
	// System
	input  wire logic                        clock,
	input  wire logic                        rst_b,
	// Serial link pins
	input  wire logic                        csB,
	input  wire logic                        sck,
	input  wire logic                        si,
	output logic                             so_q,
	output logic                             soOe_q,
	// Array read port
	output logic                             arrayRd_q,
	output logic [sflash_pkg::ADDR_W-1:0]    arrayAddr_q,
	input  wire logic [sflash_pkg::BYTE_W-1:0] arrayData,
	// Decoded command to the executing logic
	output logic [sflash_pkg::BYTE_W-1:0]    cmdOp_q,
	output logic [sflash_pkg::ADDR_W-1:0]    cmdAddr_q,
	output logic                             cmdExec_q,
	// Incoming data bytes
	output logic [sflash_pkg::BYTE_W-1:0]    rxData_q,
	output logic                             rxValid_q,
	// Reply bytes for status, identification and protection reads
	input  wire logic [sflash_pkg::BYTE_W-1:0] respData,
	output logic                             respTake_q
);

	// Synchronised pins and edge history
	logic csSync;       // Select, high is inactive
	logic sckSync;      // Serial clock
	logic siSync;       // Serial input
	logic csPrev_q;     // Select one cycle ago
	logic sckPrev_q;    // Clock one cycle ago

	// Link events
	logic csStart;      // Select just asserted
	logic csStop;       // Select just released
	logic sckRise;      // Sample edge inside a frame
	logic sckFall;      // Launch edge inside a frame
	logic byteDone;     // Eighth bit sampled on this rise

	// Framing state
	sflash_pkg::state_e    state_q;
	logic [2:0]            bitCnt_q;    // Bits taken in this byte
	logic [1:0]            addrCnt_q;   // Address bytes taken
	logic [6:0]            inSh_q;      // Partial incoming byte
	logic [7:0]            rxByte;      // Byte completed this rise
	logic                  addrDone_q;  // Opcode and address complete
	sflash_pkg::op_info_s  newInfo;     // Shape of opcode arriving now
	sflash_pkg::op_info_s  curInfo;     // Shape of the captured opcode
	logic                  isRead;      // Captured opcode is an array read
	logic                  hdrEnd;      // Address or dummy phase finishing

	// Output path
	logic [7:0]  outSh_q;     // Remaining bits of the byte on the wire
	logic [2:0]  outCnt_q;    // Bits left in the byte on the wire
	logic [2:0]  respCnt_q;   // Reply bytes sent
	logic        loadByte;    // Fall that starts a new byte
	logic        respLimit;   // Identification reply used up
	logic [7:0]  nextByte;    // Byte to launch

	// Prefetch path
	logic [sflash_pkg::ADDR_W-1:0] fetchAddr_q;  // Next array address
	logic        fetchOn_q;   // Prefetch running
	logic        fifoFlush;
	logic        fifoInReady;
	logic        fifoOutValid;
	logic [7:0]  fifoOutData;
	logic        fifoPop;

	// Opcode table
	function automatic sflash_pkg::op_info_s decode(input logic [7:0] op);
		sflash_pkg::op_info_s info;
		info = '{known: 1'b1, addr: 1'b0, dummy: 1'b0, dir: sflash_pkg::DIR_NONE};
		unique case (op)
			sflash_pkg::OP_READ_FAST: begin
				info.addr  = 1'b1;
				info.dummy = 1'b1;
				info.dir   = sflash_pkg::DIR_OUT;
			end
			sflash_pkg::OP_READ_SLOW: begin
				info.addr = 1'b1;
				info.dir  = sflash_pkg::DIR_OUT;
			end
			sflash_pkg::OP_ERASE_4K,
			sflash_pkg::OP_ERASE_32K,
			sflash_pkg::OP_ERASE_64K,
			sflash_pkg::OP_PROTECT,
			sflash_pkg::OP_UNPROTECT: begin
				info.addr = 1'b1;
			end
			sflash_pkg::OP_PROGRAM: begin
				info.addr = 1'b1;
				info.dir  = sflash_pkg::DIR_IN;
			end
			sflash_pkg::OP_RD_PROT: begin
				info.addr = 1'b1;
				info.dir  = sflash_pkg::DIR_OUT;
			end
			sflash_pkg::OP_RD_ID,
			sflash_pkg::OP_RD_STATUS: begin
				info.dir = sflash_pkg::DIR_OUT;
			end
			sflash_pkg::OP_WR_STATUS: begin
				info.dir = sflash_pkg::DIR_IN;
			end
			sflash_pkg::OP_CHIP_ERA_A,
			sflash_pkg::OP_CHIP_ERA_B,
			sflash_pkg::OP_WR_ENABLE,
			sflash_pkg::OP_WR_DISABLE,
			sflash_pkg::OP_PWR_DOWN,
			sflash_pkg::OP_RESUME: begin
				info.known = 1'b1;
			end
			default: begin  // Unsupported opcode
				info.known = 1'b0;
			end
		endcase
		return info;
	endfunction

	// Pin synchronisers; select idles high
	pin_sync #(.RESET_VAL(1'b1)) u_csSync (
		.clock  (clock),
		.rst_b  (rst_b),
		.pinIn  (csB),
		.pinOut (csSync)
	);
	pin_sync #(.RESET_VAL(1'b0)) u_sckSync (
		.clock  (clock),
		.rst_b  (rst_b),
		.pinIn  (sck),
		.pinOut (sckSync)
	);
	pin_sync #(.RESET_VAL(1'b0)) u_siSync (
		.clock  (clock),
		.rst_b  (rst_b),
		.pinIn  (si),
		.pinOut (siSync)
	);

	// Edge history of the synchronised pins
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			csPrev_q  <= 1'b1;
			sckPrev_q <= 1'b0;
		end else begin
			csPrev_q  <= csSync;
			sckPrev_q <= sckSync;
		end
	end

	// Clock edges count only inside a frame; the stray fall at frame
	// start in mode 3 meets the opcode phase and launches nothing
	assign csStart  = csPrev_q & ~csSync;
	assign csStop   = ~csPrev_q & csSync;
	assign sckRise  = sckSync & ~sckPrev_q & ~csSync;
	assign sckFall  = ~sckSync & sckPrev_q & ~csSync;
	assign byteDone = sckRise && (bitCnt_q == sflash_pkg::BIT_LAST);
	assign rxByte   = {inSh_q, siSync};
	assign newInfo  = decode(rxByte);
	assign curInfo  = decode(cmdOp_q);
	assign isRead   = (cmdOp_q == sflash_pkg::OP_READ_FAST)
	               || (cmdOp_q == sflash_pkg::OP_READ_SLOW);
	assign hdrEnd   = byteDone && ((state_q == sflash_pkg::ST_DUMMY)
	               || (state_q == sflash_pkg::ST_ADDR && addrCnt_q == sflash_pkg::ADDR_LAST
	                   && !curInfo.dummy));

	// Bit counter and input shifter; a release mid-byte just drops it
	always_ff @(posedge clock) begin
		if (!rst_b || csStart) begin
			bitCnt_q <= '0;
			inSh_q   <= '0;
		end else if (sckRise) begin
			bitCnt_q <= bitCnt_q + 1'b1;
			inSh_q   <= rxByte[6:0];
		end
	end

	// Framing state machine
	always_ff @(posedge clock) begin
		if (!rst_b || csStop) begin
			state_q <= sflash_pkg::ST_IDLE;
		end else if (csStart) begin
			state_q <= sflash_pkg::ST_OPCODE;
		end else if (byteDone) begin
			unique case (state_q)
				sflash_pkg::ST_OPCODE: begin
					if (!newInfo.known) begin
						state_q <= sflash_pkg::ST_IGNORE;
					end else if (newInfo.addr) begin
						state_q <= sflash_pkg::ST_ADDR;
					end else if (newInfo.dir == sflash_pkg::DIR_OUT) begin
						state_q <= sflash_pkg::ST_OUT;
					end else if (newInfo.dir == sflash_pkg::DIR_IN) begin
						state_q <= sflash_pkg::ST_IN;
					end else begin
						state_q <= sflash_pkg::ST_SKIP;  // Extra bytes ignored
					end
				end
				sflash_pkg::ST_ADDR: begin
					if (addrCnt_q != sflash_pkg::ADDR_LAST) begin
						state_q <= sflash_pkg::ST_ADDR;
					end else if (curInfo.dummy) begin
						state_q <= sflash_pkg::ST_DUMMY;
					end else if (curInfo.dir == sflash_pkg::DIR_OUT) begin
						state_q <= sflash_pkg::ST_OUT;
					end else if (curInfo.dir == sflash_pkg::DIR_IN) begin
						state_q <= sflash_pkg::ST_IN;
					end else begin
						state_q <= sflash_pkg::ST_SKIP;
					end
				end
				sflash_pkg::ST_DUMMY: begin
					state_q <= sflash_pkg::ST_OUT;
				end
				// Data phases and ignore hold until release
				sflash_pkg::ST_IDLE,
				sflash_pkg::ST_OUT,
				sflash_pkg::ST_IN,
				sflash_pkg::ST_SKIP,
				sflash_pkg::ST_IGNORE: begin
					state_q <= state_q;
				end
			endcase
		end
	end

	// Opcode, address capture and completeness
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			cmdOp_q    <= '0;
			cmdAddr_q  <= '0;
			addrCnt_q  <= '0;
			addrDone_q <= 1'b0;
		end else if (csStart) begin
			addrCnt_q  <= '0;
			addrDone_q <= 1'b0;
		end else if (byteDone && state_q == sflash_pkg::ST_OPCODE) begin
			cmdOp_q    <= rxByte;
			addrDone_q <= newInfo.known && !newInfo.addr;
		end else if (byteDone && state_q == sflash_pkg::ST_ADDR) begin
			// Older bytes shift out the top, dropping the unused high bits
			cmdAddr_q  <= sflash_pkg::ADDR_W'({cmdAddr_q, rxByte});
			addrCnt_q  <= addrCnt_q + 1'b1;
			addrDone_q <= (addrCnt_q == sflash_pkg::ADDR_LAST);
		end
	end

	// Command hand-off at release, only for a complete header
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			cmdExec_q <= 1'b0;
		end else begin
			cmdExec_q <= csStop && addrDone_q;
		end
	end

	// Incoming data bytes for program and status write
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rxData_q  <= '0;
			rxValid_q <= 1'b0;
		end else begin
			rxValid_q <= byteDone && state_q == sflash_pkg::ST_IN;
			if (byteDone && state_q == sflash_pkg::ST_IN) begin
				rxData_q <= rxByte;
			end
		end
	end

	// Prefetch control; the counter width makes the top wrap to zero
	always_ff @(posedge clock) begin
		if (!rst_b || csStop || csStart) begin
			fetchOn_q   <= 1'b0;
			fetchAddr_q <= '0;
			arrayRd_q   <= 1'b0;
			arrayAddr_q <= '0;
		end else begin
			if (hdrEnd && isRead) begin
				fetchOn_q   <= 1'b1;
				fetchAddr_q <= (state_q == sflash_pkg::ST_ADDR) ?
				               sflash_pkg::ADDR_W'({cmdAddr_q, rxByte}) : cmdAddr_q;
			end else if (fetchOn_q && !arrayRd_q && fifoInReady) begin
				// One read in flight keeps the FIFO from overfilling
				fetchAddr_q <= fetchAddr_q + 1'b1;
			end
			arrayRd_q <= fetchOn_q && !arrayRd_q && fifoInReady;
			if (fetchOn_q && !arrayRd_q && fifoInReady) begin
				arrayAddr_q <= fetchAddr_q;
			end
		end
	end

	// Flush on both frame edges so no stale bytes survive a frame
	assign fifoFlush = csStart | csStop;

	data_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_prefetch (
		.clock    (clock),
		.rst_b    (rst_b),
		.flush    (fifoFlush),
		.inValid  (arrayRd_q),
		.inData   (arrayData),
		.inReady  (fifoInReady),
		.outValid (fifoOutValid),
		.outData  (fifoOutData),
		.outReady (fifoPop)
	);

	// Byte selection at the first fall of each outgoing byte
	assign loadByte  = sckFall && state_q == sflash_pkg::ST_OUT && outCnt_q == '0;
	assign fifoPop   = loadByte && isRead;
	assign respLimit = (cmdOp_q == sflash_pkg::OP_RD_ID) && (respCnt_q == sflash_pkg::ID_MAX);
	assign nextByte  = !isRead ? respData :
	                   fifoOutValid ? fifoOutData : sflash_pkg::EMPTY_FILL;

	// Reply byte count and take strobe for non-array replies
	always_ff @(posedge clock) begin
		if (!rst_b || csStart) begin
			respCnt_q  <= '0;
			respTake_q <= 1'b0;
		end else begin
			respTake_q <= loadByte && !isRead && !respLimit;
			if (loadByte && !isRead && !respLimit) begin
				respCnt_q <= respCnt_q + 1'b1;
			end
		end
	end

	// Output shifter, launched on falling edges, MSB first
	always_ff @(posedge clock) begin
		if (!rst_b || csStart) begin
			outSh_q  <= '0;
			outCnt_q <= '0;
			so_q     <= 1'b0;
		end else if (sckFall && state_q == sflash_pkg::ST_OUT) begin
			if (loadByte) begin
				so_q     <= nextByte[7];
				outSh_q  <= {nextByte[6:0], 1'b0};
				outCnt_q <= sflash_pkg::BIT_LAST;
			end else begin
				so_q     <= outSh_q[7];
				outSh_q  <= {outSh_q[6:0], 1'b0};
				outCnt_q <= outCnt_q - 1'b1;
			end
		end
	end

	// Output enable: only in a data-out phase, released with select
	always_ff @(posedge clock) begin
		if (!rst_b || csStop || state_q != sflash_pkg::ST_OUT) begin
			soOe_q <= 1'b0;
		end else if (loadByte) begin
			soOe_q <= !((!isRead) && respLimit);
		end
	end

endmodule
